// [rtl/adc_ctl_pkg.sv]
/*
 * Constants, types and helper functions shared by the converter control logic.
 * Assumes a single 125 MHz system clock and a synchronous, active-high reset.
 */
// Notes on behaviour
// - Busy rises when a conversion starts, falls after the result is latched.
// - Master read-after-convert mode uses a longer busy duration than other modes.
// - Range: neither 0-5 V, span-ten 0-10 V, signed +-5 V, both +-10 V.
// - Output bus is enabled only while chip select and read are both low.
// - Chip select gates the external serial clock, never the configuration port.
// - Reset held high aborts any conversion in progress.
// - Leaving reset clears configuration; straight-binary format gives all-zero data.
// - Power-down lets the current conversion finish, then blocks new ones.
// - In parallel mode the shared pin drives data bit fifteen.
// - In serial configuration mode the shared pin is the configuration port select.
// - Serial configuration mode means serial selected and software configuration.
package adc_ctl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int BUSY_NORMAL_NS = 1200;
    localparam int BUSY_RAC_NS    = 1500;

    // least time: round up, never below one cycle
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int BUSY_NORMAL_CYC = ns_to_cycles(BUSY_NORMAL_NS);
    localparam int BUSY_RAC_CYC    = ns_to_cycles(BUSY_RAC_NS);

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int              DATA_W      = 16;
    localparam int              CFG_W       = 8;
    localparam int              FIFO_DEPTH  = 4;
    localparam int              BUSY_CNT_W  = 16;
    localparam logic [15:0]     DATA_RST_SB = 16'h0000;
    localparam logic [15:0]     DATA_RST_TC = 16'h8000;
    localparam logic [7:0]      CFG_RST     = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RANGE_0_5V,
        RANGE_0_10V,
        RANGE_PM5V,
        RANGE_PM10V
    } range_t;

    typedef enum {
        CONV_IDLE,
        CONV_RUN
    } conv_state_t;

    function automatic range_t decode_range(input logic signed_sel, input logic ten_sel);
        unique case ({signed_sel, ten_sel})
            2'b00: return RANGE_0_5V;
            2'b01: return RANGE_0_10V;
            2'b10: return RANGE_PM5V;
            2'b11: return RANGE_PM10V;
        endcase
    endfunction

endpackage

// [rtl/sample_fifo.sv]
/*
 * Small synchronous FIFO for converted samples, valid/ready on both sides.
 * Assumes one clock; reset empties it in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sample_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count  = count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage needs no reset; empty flag guards reads
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule
`default_nettype wire

// [rtl/adc_control_pin_logic.sv]
/*
 * Digital control and status logic of the converter: busy, range decode,
 * output bus enables, serial clock gating, serial configuration port and reset.
 * Assumes all pins are asynchronous to clk_sys and the converter core hands
 * its result on sar_code in the clk_sys domain.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_control_pin_logic
    import adc_ctl_pkg::*;
#(
    parameter int BUSY_NORMAL = BUSY_NORMAL_CYC,
    parameter int BUSY_RAC    = BUSY_RAC_CYC
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // conversion
    input  wire logic              conv_start_n,
    input  wire logic [DATA_W-1:0] sar_code,
    output logic                   busy,
    output logic                   powered_down,
    // mode straps
    input  wire logic              serial_parallel_select,
    input  wire logic              hardware_software_config_select,
    input  wire logic              external_internal_clock_select,
    input  wire logic              read_during_convert,
    input  wire logic              output_format_select,
    input  wire logic              power_down_in,
    // input range
    input  wire logic              bipolar_select,
    input  wire logic              span_ten_select,
    output range_t                 range_sel,
    // output bus
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    output logic      [DATA_W-2:0] data_out,
    output logic                   data_oe,
    input  wire logic              data_bit_fifteen_in,
    output logic                   data_bit_fifteen_out,
    output logic                   data_bit_fifteen_oe,
    // serial read-out
    input  wire logic              serial_clk_in,
    output logic                   serial_data_out,
    output logic                   serial_data_oe,
    // serial configuration
    input  wire logic              cfg_clk_in,
    input  wire logic              cfg_data_in,
    output logic      [CFG_W-1:0]  cfg_word
);
    if (BUSY_NORMAL < 2 || BUSY_RAC < 2 || BUSY_NORMAL >= (1 << BUSY_CNT_W)
        || BUSY_RAC >= (1 << BUSY_CNT_W)) begin : g_bad_busy
        $error("busy durations must be at least two cycles and fit the busy counter");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 16;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_s;
    logic [NPIN-1:0] pin_d;

    assign pin_raw = {conv_start_n, serial_parallel_select, hardware_software_config_select,
                      external_internal_clock_select, read_during_convert, output_format_select,
                      power_down_in, bipolar_select, span_ten_select, cs_n, rd_n,
                      data_bit_fifteen_in, serial_clk_in, cfg_clk_in, cfg_data_in, 1'b0};

    always_ff @(posedge clk_sys) begin
        pin_meta <= pin_raw;
        pin_s    <= pin_meta;
        pin_d    <= pin_s;
    end

    logic start_n_s, ser_s, hw_s, ext_s, rdc_s, fmt_s, pd_s, bip_s, ten_s;
    logic cs_n_s, rd_n_s, cfg_port_select_n, sclk_s, cfgclk_s, cfgdat_s;
    assign {start_n_s, ser_s, hw_s, ext_s, rdc_s, fmt_s, pd_s, bip_s, ten_s, cs_n_s, rd_n_s,
            cfg_port_select_n, sclk_s, cfgclk_s, cfgdat_s} = pin_s[NPIN-1:1];

    logic start_fall, sclk_rise, cfgclk_rise;
    assign start_fall  = pin_d[15] & ~start_n_s;
    assign sclk_rise   = ~pin_d[3] & sclk_s;
    assign cfgclk_rise = ~pin_d[2] & cfgclk_s;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic parallel_mode, slave_serial, master_rac, cfg_mode, bus_en_cond;
    assign parallel_mode = ~ser_s;
    assign slave_serial  = ser_s & ext_s;
    assign master_rac    = ser_s & ~ext_s & ~rdc_s;
    assign cfg_mode      = ser_s & ~hw_s;
    assign bus_en_cond   = ~cs_n_s & ~rd_n_s;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    conv_state_t             state, next_state;
    logic [BUSY_CNT_W-1:0]   cnt, next_cnt;
    logic [BUSY_CNT_W-1:0]   target, next_target;
    logic                    start_ok;
    logic                    done;
    logic                    fifo_in_ready;

    // a full FIFO refuses new conversions so no sample is overwritten
    assign start_ok = start_fall & ~pd_s & fifo_in_ready;
    assign done     = (state == CONV_RUN) && (cnt == target - BUSY_CNT_W'(1));

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_target = target;
        unique case (state)
            CONV_IDLE: begin
                if (start_ok) begin
                    next_state  = CONV_RUN;
                    next_cnt    = '0;
                    next_target = master_rac ? BUSY_CNT_W'(BUSY_RAC)
                                             : BUSY_CNT_W'(BUSY_NORMAL);
                end
            end
            CONV_RUN: begin
                next_cnt = cnt + BUSY_CNT_W'(1);
                if (done) begin
                    next_state = CONV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state  <= CONV_IDLE;
            cnt    <= '0;
            target <= BUSY_CNT_W'(BUSY_NORMAL);
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            target <= next_target;
        end
    end

    assign busy         = (state == CONV_RUN);
    assign powered_down = pd_s & ~busy;

    // ------------------------------------------------------------
    // result buffer and output bus
    // ------------------------------------------------------------
    logic              fifo_out_valid;
    logic              pop;
    logic [DATA_W-1:0] fifo_head;
    logic              bus_en;
    logic              next_bus_en;

    // the word leaves the FIFO when the host ends its read
    assign pop = bus_en & ~bus_en_cond & fifo_out_valid;

    sample_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (done),
        .in_ready  (fifo_in_ready),
        .in_data   (sar_code),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_head)
    );

    logic [DATA_W-1:0] data_word, next_data_word;
    logic [DATA_W-1:0] shreg, next_shreg;
    logic              sclk_gated;

    assign sclk_gated = sclk_rise & ~cs_n_s & slave_serial;

    always_comb begin
        next_bus_en    = bus_en_cond;
        next_data_word = fifo_out_valid ? fifo_head : data_word;
        next_shreg     = shreg;
        if (bus_en_cond & ~bus_en) begin
            next_shreg = next_data_word;
        end else if (sclk_gated) begin
            next_shreg = {shreg[DATA_W-2:0], 1'b0};
        end
        if (rst) begin
            next_bus_en    = 1'b0;
            next_data_word = fmt_s ? DATA_RST_SB : DATA_RST_TC;
            next_shreg     = next_data_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        bus_en    <= next_bus_en;
        data_word <= next_data_word;
        shreg     <= next_shreg;
    end

    assign data_out             = data_word[DATA_W-2:0];
    assign data_oe              = bus_en & parallel_mode;
    assign data_bit_fifteen_out = data_word[DATA_W-1];
    assign data_bit_fifteen_oe  = bus_en & parallel_mode;
    assign serial_data_out      = shreg[DATA_W-1];
    assign serial_data_oe       = bus_en & ser_s;

    // ------------------------------------------------------------
    // serial configuration port
    // ------------------------------------------------------------
    logic [CFG_W-1:0] next_cfg_word;
    logic             cfg_shift;

    // chip select plays no part here, only the shared select pin
    assign cfg_shift = cfg_mode & ~cfg_port_select_n & cfgclk_rise;

    always_comb begin
        next_cfg_word = cfg_word;
        if (cfg_shift) begin
            next_cfg_word = {cfg_word[CFG_W-2:0], cfgdat_s};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_word <= CFG_RST;
        end else begin
            cfg_word <= next_cfg_word;
        end
    end

    // ------------------------------------------------------------
    // input range
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        range_sel <= decode_range(bip_s, ten_s);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [BUSY_CNT_W-1:0] busy_age;
    logic                  lat_rac;
    always_ff @(posedge clk_sys) begin
        busy_age <= busy ? busy_age + BUSY_CNT_W'(1) : '0;
        if (start_ok && state == CONV_IDLE) begin
            lat_rac <= master_rac;
        end
    end

    sequence s_start;
        state == CONV_IDLE && start_ok;
    endsequence

    sequence s_busy_two;
        busy [*2];
    endsequence

    a_busy_start: assert property (@(posedge clk_sys) disable iff (rst)
        s_start |=> s_busy_two) else $error("busy did not rise on start");
    a_busy_len: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(busy) && !$past(rst) |-> busy_age == (lat_rac ? BUSY_CNT_W'(BUSY_RAC)
                                                            : BUSY_CNT_W'(BUSY_NORMAL)))
        else $error("busy length wrong for mode");
    a_range_map: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 range_sel == range_t'({$past(bip_s), $past(ten_s)})) else $error("range decode wrong");
    a_bus_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (data_oe || serial_data_oe) |-> $past(!cs_n_s && !rd_n_s)) else $error("bus on without select");
    a_sclk_gate: assert property (@(posedge clk_sys) disable iff (rst)
        cs_n_s && !(bus_en_cond && !bus_en) |=> $stable(shreg)) else $error("shift without chip select");
    a_reset_abort: assert property (@(posedge clk_sys)
        rst |=> !busy) else $error("reset did not abort conversion");
    a_reset_clear: assert property (@(posedge clk_sys)
        rst && fmt_s |=> cfg_word == CFG_RST && data_word == DATA_RST_SB)
        else $error("reset did not clear outputs");
    a_pd_inhibit: assert property (@(posedge clk_sys) disable iff (rst)
        pd_s && !busy |=> !busy) else $error("conversion started in power-down");
    a_d15_drive: assert property (@(posedge clk_sys) disable iff (rst)
        data_bit_fifteen_oe |-> parallel_mode && data_bit_fifteen_out == data_word[DATA_W-1])
        else $error("shared pin not driven as bit fifteen");
    a_cfg_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !(cfg_mode && !cfg_port_select_n) |=> $stable(cfg_word)) else $error("config changed unselected");
    a_cfg_mode: assert property (@(posedge clk_sys) disable iff (rst)
        (!ser_s || hw_s) |=> $stable(cfg_word)) else $error("config changed outside software mode");
    a_bus_hiz: assert property (@(posedge clk_sys) disable iff (rst)
        !bus_en_cond |=> !data_oe && !serial_data_oe && !data_bit_fifteen_oe)
        else $error("bus not released");

endmodule
`default_nettype wire

// [tb/adc_host_model.sv]
/*
 * Host controller model: read strobes, serial clock, configuration
 * clock and data, and its side of the shared bit-fifteen pin.
 * Each task first waits for a rising clk_sys edge (sclk_pulse returns at once while cs_n is high), so the bench may call it at either edge.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    // clock
    input  wire logic clk_sys,
    // read strobes
    output logic      cs_n,
    output logic      rd_n,
    // serial and configuration lines
    output logic      serial_clk_in,
    output logic      cfg_clk_in,
    output logic      cfg_data_in,
    // shared pin
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in
);
    logic host_oe;
    logic host_val;

    // pulled up when nobody drives it
    assign pin_in = pin_oe ? pin_out : (host_oe ? host_val : 1'b1);

    initial begin
        cs_n          = 1'b1;
        rd_n          = 1'b1;
        serial_clk_in = 1'b0;
        cfg_clk_in    = 1'b0;
        cfg_data_in   = 1'b0;
        host_oe       = 1'b0;
        host_val      = 1'b1;
    end

    task automatic set_strobe(input logic c, input logic r);
        @(posedge clk_sys);
        cs_n <= c;
        rd_n <= r;
    endtask

    // clock stands still unless the device is selected
    task automatic sclk_pulse();
        if (cs_n !== 1'b0) return;
        @(posedge clk_sys);
        serial_clk_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        serial_clk_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    // host drives the shared pin whenever enabled, unless the device is driving it
    task automatic drive_pin(input logic en, input logic v);
        @(posedge clk_sys);
        host_oe  <= en;
        host_val <= v;
    endtask

    // data inverted after the hold time so stale bits are never read
    task automatic cfg_bit(input logic b);
        @(posedge clk_sys);
        cfg_data_in <= b;
        repeat (4) @(posedge clk_sys);
        cfg_clk_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cfg_clk_in  <= 1'b0;
        cfg_data_in <= ~b;
    endtask
endmodule
`default_nettype wire

// [tb/test_adc_control_pin_logic.sv]
/*
 * Self-checking bench for the converter control logic, with a queue model.
 * Assumes shortened busy counts and a pulled-up shared pin.
 */
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_pin_logic
    import adc_ctl_pkg::*;
;
    localparam int BN = 6;
    localparam int BR = 9;
    logic clk_sys, rst, conv_start_n, busy, powered_down;
    logic serial_parallel_select, hardware_software_config_select;
    logic external_internal_clock_select, read_during_convert;
    logic output_format_select, power_down_in, bipolar_select, span_ten_select;
    logic cs_n, rd_n, data_oe, serial_clk_in, serial_data_out, serial_data_oe;
    logic data_bit_fifteen_in, data_bit_fifteen_out, data_bit_fifteen_oe;
    logic cfg_clk_in, cfg_data_in;
    logic [DATA_W-1:0] sar_code;
    logic [DATA_W-2:0] data_out;
    logic [CFG_W-1:0]  cfg_word;
    range_t            range_sel;
    range_t            rng[4] = '{RANGE_0_5V, RANGE_0_10V, RANGE_PM5V, RANGE_PM10V};
    logic [15:0]       q[$];
    int                errors;
    int                n_checks;

    adc_control_pin_logic #(.BUSY_NORMAL(BN), .BUSY_RAC(BR)) i_adc_control_pin_logic (.*);
    adc_host_model i_host (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n),
        .serial_clk_in(serial_clk_in), .cfg_clk_in(cfg_clk_in), .cfg_data_in(cfg_data_in),
        .pin_out(data_bit_fifteen_out), .pin_oe(data_bit_fifteen_oe), .pin_in(data_bit_fifteen_in));

    always #4 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_level(input bit ser, input logic v);
        int k;
        logic s;
        k = 0;
        @(negedge clk_sys);
        s = ser ? serial_data_oe : data_oe;
        while (s !== v && k < 12) begin
            k++;
            @(negedge clk_sys);
            s = ser ? serial_data_oe : data_oe;
        end
        check(16'(s), 16'(v), "handshake");
    endtask

    // refused starts give len 0 and add nothing to the model
    task automatic conv(output int len);
        logic [15:0] code;
        int w;
        code = 16'($urandom);
        @(posedge clk_sys);
        sar_code     <= code;
        conv_start_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        conv_start_n <= 1'b1;
        len = 0;
        w   = 0;
        @(negedge clk_sys);
        while (busy !== 1'b1 && w < 6) begin
            w++;
            @(negedge clk_sys);
        end
        while (busy === 1'b1 && len < 400) begin
            len++;
            @(negedge clk_sys);
        end
        if (len > 0) q.push_back(code);
    endtask

    task automatic read_par(output logic [15:0] w);
        @(negedge clk_sys);
        check(16'({data_oe, data_bit_fifteen_oe}), 16'h0, "bus on while idle");
        i_host.set_strobe(1'b0, 1'b0);
        wait_level(1'b0, 1'b1);
        check(16'({data_bit_fifteen_oe, serial_data_oe}), 16'h2, "enables");
        w = {data_bit_fifteen_out, data_out};
        i_host.set_strobe(1'b1, 1'b1);
        wait_level(1'b0, 1'b0);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic drain_par(input int n);
        logic [15:0] w;
        repeat (n) begin
            read_par(w);
            check(w, q.pop_front(), "parallel word");
        end
    endtask

    task automatic read_ser(output logic [15:0] w);
        i_host.set_strobe(1'b0, 1'b0);
        wait_level(1'b1, 1'b1);
        check(16'(data_oe), 16'h0, "parallel bus in serial");
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_sys);
            w[i] = serial_data_out;
            i_host.sclk_pulse();
        end
        i_host.set_strobe(1'b1, 1'b1);
        wait_level(1'b1, 1'b0);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic shift_cfg(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) i_host.cfg_bit(v[i]);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // reset pulse in mid-run; the model forgets queued words
    task automatic pulse_reset();
        repeat (5) @(posedge clk_sys);
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        q.delete();
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        logic [15:0] w;
        logic [7:0]  b;
        int          len;
        clk_sys = 1'b0;
        rst = 1'b1;
        conv_start_n = 1'b1;
        sar_code = 16'h0000;
        serial_parallel_select = 1'b0;
        hardware_software_config_select = 1'b1;
        external_internal_clock_select = 1'b1;
        read_during_convert = 1'b0;
        output_format_select = 1'b1;
        power_down_in = 1'b0;
        bipolar_select = 1'b0;
        span_ten_select = 1'b0;
        errors = 0;
        n_checks = 0;
        void'($urandom(88368));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(16'({busy, cfg_word}), 16'h0, "busy or cfg after reset");
        read_par(w);
        check(w, 16'h0000, "data after reset");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            bipolar_select  <= k[1];
            span_ten_select <= k[0];
            repeat (5) @(posedge clk_sys);
            @(negedge clk_sys);
            check(16'(range_sel), 16'(rng[k]), "range");
        end
        $display("test range done");
        for (int k = 0; k < 5; k++) begin
            conv(len);
            check(16'(len), (k < 4) ? 16'(BN) : 16'h0, "busy length");
        end
        i_host.set_strobe(1'b0, 1'b1);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check(16'({data_oe, data_bit_fifteen_oe}), 16'h0, "bus on, cs only");
        i_host.set_strobe(1'b1, 1'b1);
        drain_par(4);
        $display("test fifo done");
        fork
            conv(len);
            begin
                repeat (4) @(posedge clk_sys);
                power_down_in <= 1'b1;
            end
        join
        check(16'(len), 16'(BN), "busy under power-down");
        conv(len);
        check(16'({len != 0, powered_down}), 16'h1, "start in power-down");
        @(posedge clk_sys);
        power_down_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        drain_par(1);
        $display("test power-down done");
        serial_parallel_select <= 1'b1;
        repeat (4) @(posedge clk_sys);
        conv(len);
        check(16'(len), 16'(BN), "busy slave serial");
        read_ser(w);
        check(w, q.pop_front(), "serial word");
        external_internal_clock_select <= 1'b0;
        repeat (4) @(posedge clk_sys);
        conv(len);
        check(16'(len), 16'(BR), "busy read after convert");
        @(posedge clk_sys);
        read_during_convert <= 1'b1;
        repeat (4) @(posedge clk_sys);
        conv(len);
        check(16'(len), 16'(BN), "busy read during convert");
        $display("test serial done");
        @(posedge clk_sys);
        hardware_software_config_select <= 1'b0;
        i_host.drive_pin(1'b1, 1'b0);
        b = 8'($urandom);
        shift_cfg(b);
        check(16'(cfg_word), 16'(b), "cfg loaded, cs high");
        i_host.drive_pin(1'b1, 1'b1);
        shift_cfg(~b);
        check(16'(cfg_word), 16'(b), "cfg port deselected");
        @(posedge clk_sys);
        hardware_software_config_select <= 1'b1;
        i_host.drive_pin(1'b1, 1'b0);
        shift_cfg(~b);
        check(16'(cfg_word), 16'(b), "cfg in hardware mode");
        i_host.drive_pin(1'b0, 1'b0);
        $display("test config done");
        serial_parallel_select <= 1'b0;
        output_format_select   <= 1'b0;
        repeat (4) @(posedge clk_sys);
        fork
            conv(len);
            pulse_reset();
        join
        check(16'(len > 0 && len < BN), 16'h1, "conversion aborted");
        @(negedge clk_sys);
        check(16'(cfg_word), 16'h0, "cfg after reset");
        read_par(w);
        check(w, DATA_RST_TC, "data after reset, signed format");
        $display("test abort done");
        complete_run();
    end
endmodule
`default_nettype wire
